// File: logic/ddsp_gate_if.sv
// Purpose: Carries stage on and gate selection bits to the PWM gating module
// Assumes: Widths from the shared package
// Notes: ctrl side drives, gate side listens
interface ddsp_gate_if;
  import ddsp_pkg::*;
  logic [NUM_STAGES-1:0] stage_on;
  logic [NUM_STAGES-1:0] gate_a_select;
  logic [NUM_STAGES-1:0] gate_b_select;
  modport ctrl (output stage_on, output gate_a_select, output gate_b_select);
  modport gate (input stage_on, input gate_a_select, input gate_b_select);
endinterface

// File: logic/ddsp_pkg.sv
// Purpose: Shared constants, types and helpers of the door driver serial diagnosis block
// Assumes: 16-bit frames, four status words, eight gateable power stages
// Notes: Flag masks keep unconnected status positions at zero
package ddsp_pkg;

  localparam int FRAME_BITS = 16;
  localparam int WORD_FLAGS = 10;
  localparam int NUM_WORDS = 4;
  localparam int CTRL_BITS = 13;
  localparam int NUM_STAGES = 8;

  localparam logic [4:0] FRAME_LEN = 5'h10;

  // Received frame layout
  localparam int ADDR_LSB = 0;
  localparam int ADDR_MSB = 1;
  localparam int CLR_POS = 2;
  localparam int CTRL_LSB = 3;

  // Returned word layout
  localparam int FLAG_LSB = 6;
  localparam int SUPPLY_POS = 5;
  localparam int TSD_POS = 4;
  localparam int TW_POS = 3;

  // Status word addresses
  localparam logic [1:0] ADDR_LH_OVL = 2'h0;
  localparam logic [1:0] ADDR_LH_OPL = 2'h1;
  localparam logic [1:0] ADDR_ML_OVL = 2'h2;
  localparam logic [1:0] ADDR_ML_OPL = 2'h3;
  localparam logic [1:0] ADDR_RESET = ADDR_LH_OVL;

  // Control words that steer the power stages
  localparam logic [1:0] CTRL_ON_WORD = 2'h0;
  localparam logic [1:0] CTRL_SEL_A_WORD = 2'h1;
  localparam logic [1:0] CTRL_SEL_B_WORD = 2'h3;
  localparam logic [CTRL_BITS-1:0] CTRL_RESET = 13'h0000;

  // Connected flag positions per word, word 3 first
  localparam logic [NUM_WORDS-1:0][WORD_FLAGS-1:0] FLAG_MASK =
    {10'h2BF, 10'h3FF, 10'h2A8, 10'h3F8};

  typedef enum logic [1:0] {
    DDSP_IDLE = 2'b01,
    DDSP_SHIFT = 2'b10
  } ddsp_state_t;

  // Error indications of the three words other than w, highest word first
  function automatic logic [2:0] ddsp_other_errors(input logic [3:0] ef, input logic [1:0] w);
    logic [2:0] r;
    r = 3'h0;
    unique case (w)
      2'h0: r = {ef[3], ef[2], ef[1]};
      2'h1: r = {ef[3], ef[2], ef[0]};
      2'h2: r = {ef[3], ef[1], ef[0]};
      2'h3: r = {ef[2], ef[1], ef[0]};
    endcase
    return r;
  endfunction

endpackage

// File: logic/ddsp_pwm_gate.sv
// Purpose: Gates each power stage by its on bit and the two direct gate pins
// Assumes: Gate pins are asynchronous and pass two flip-flops first
// Notes: Stage drive is registered, three clocks behind a pin change
module ddsp_pwm_gate
  import ddsp_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic direct_gate_input_a_in,
  input wire logic direct_gate_input_b_in,
  ddsp_gate_if.gate cfg,
  output logic [NUM_STAGES-1:0] stage_drive_out
);

  typedef struct packed {
    logic [1:0] a_s;
    logic [1:0] b_s;
    logic [NUM_STAGES-1:0] drive;
  } ddsp_gate_st_t;

  ddsp_gate_st_t st_r;
  ddsp_gate_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.a_s = {st_r.a_s[0], direct_gate_input_a_in};
    st_nxt.b_s = {st_r.b_s[0], direct_gate_input_b_in};
    // Unselected stages follow the on bit; selected ones OR their pins
    st_nxt.drive = cfg.stage_on & ((~cfg.gate_a_select & ~cfg.gate_b_select)
                 | (cfg.gate_a_select & {NUM_STAGES{st_r.a_s[1]}})
                 | (cfg.gate_b_select & {NUM_STAGES{st_r.b_s[1]}}));
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stage_drive_out = st_r.drive;

  default clocking gate_cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  AST_GATE_SERIAL: assert property (
    1'b1 |=> ((st_r.drive ^ $past(cfg.stage_on)) & ~$past(cfg.gate_a_select)
              & ~$past(cfg.gate_b_select)) == '0)
    else $error("unselected stage does not follow its on bit");

  AST_GATE_OFF: assert property (
    1'b1 |=> (st_r.drive & ~$past(cfg.stage_on)) == '0)
    else $error("stage driven while its on bit is low");

  AST_GATE_A_ONLY: assert property (
    !st_r.a_s[1] |=> (st_r.drive & $past(cfg.gate_a_select) & ~$past(cfg.gate_b_select)) == '0)
    else $error("gate a stage on while pin a is low");

  AST_GATE_EITHER: assert property (
    (st_r.a_s[1] || st_r.b_s[1]) |=>
      ((~st_r.drive) & $past(cfg.stage_on) & ($past(cfg.gate_a_select)
       & $past(cfg.gate_b_select))) == '0)
    else $error("doubly selected stage off while a gate pin is high");

endmodule // ddsp_pwm_gate

// File: logic/ddsp_spi_diag.sv
// Purpose: Serial diagnosis port, status words and stage control of the door driver
// Assumes: Serial clock idles low, data out changes on falling and is sampled on rising edges
// Notes: All pins pass two flip-flops; a frame counts only with at least 16 falling edges
// What this block does
// - Set low-side overload bit on shutdown
// - Set high-side overload bit on shutdown
// - Set open-load bit on undercurrent
// - Unconnected status positions always read low
// - Two address bits pick returned word
// - Bits 5..3 carry supply, shutdown, warning
// - Summary bit ORs all word errors
// - Summary bit shown before first clock
// - Sixteen bits follow the summary bit
// - Plain shift register, daisy-chain capable
// - Frame takes effect at chip select rise
// - Word returned in the frame after address
// - Status address resets to zero
// - Clear happens after next frame shifts out
// - Any word clear also clears thermal shutdown
// - Control words one, three hold selections
// - Unselected stage follows only its on bit
// - Selected stage follows its gate pin
// - Both selected: either pin turns stage on
module ddsp_spi_diag
  import ddsp_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic sclk_in,
  input wire logic chip_select_low_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  input wire logic direct_gate_input_a_in,
  input wire logic direct_gate_input_b_in,
  input wire logic [NUM_WORDS*WORD_FLAGS-1:0] status_set_in,
  input wire logic supply_fault_flag_in,
  input wire logic thermal_shutdown_evt_in,
  input wire logic temperature_warning_flag_in,
  output logic [NUM_STAGES-1:0] stage_drive_out
);

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] csn_s;
    logic [1:0] mosi_s;
    ddsp_state_t state;
    logic [FRAME_BITS-1:0] shreg;
    logic samp;
    logic dout;
    logic [4:0] cnt;
    logic [1:0] sel;
    logic clr_pend;
    logic [NUM_WORDS-1:0][WORD_FLAGS-1:0] stat;
    logic thermal_shutdown_flag;
    logic [NUM_WORDS-1:0][CTRL_BITS-1:0] ctrl;
  } ddsp_st_t;

  ddsp_st_t st_r;
  ddsp_st_t st_nxt;

  logic sclk_rise;
  logic sclk_fall;
  logic csn_fall;
  logic csn_rise;
  logic [NUM_WORDS-1:0] word_err;
  logic error_summary_bit;
  logic [FRAME_BITS-1:0] cur_word;
  logic frame_ok;
  logic [NUM_WORDS*WORD_FLAGS-1:0] set_masked;

  // Edges come from the second and third sync stages only
  assign sclk_rise = st_r.sclk_s[1] & ~st_r.sclk_s[2];
  assign sclk_fall = ~st_r.sclk_s[1] & st_r.sclk_s[2];
  assign csn_fall = ~st_r.csn_s[1] & st_r.csn_s[2];
  assign csn_rise = st_r.csn_s[1] & ~st_r.csn_s[2];
  assign frame_ok = (st_r.cnt == FRAME_LEN);

  assign set_masked = status_set_in & FLAG_MASK;

  always_comb begin
    for (int w = 0; w < NUM_WORDS; w++) begin
      word_err[w] = |st_r.stat[w];
    end
    error_summary_bit = |word_err;
    cur_word = {st_r.stat[st_r.sel],
                supply_fault_flag_in, st_r.thermal_shutdown_flag,
                temperature_warning_flag_in,
                ddsp_other_errors(word_err, st_r.sel)};
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_s = {st_r.sclk_s[1:0], sclk_in};
    st_nxt.csn_s = {st_r.csn_s[1:0], chip_select_low_in};
    st_nxt.mosi_s = {st_r.mosi_s[0], mosi_in};
    unique case (st_r.state)
      DDSP_IDLE: begin
        if (csn_fall) begin
          st_nxt.state = DDSP_SHIFT;
          st_nxt.shreg = cur_word;
          st_nxt.dout = error_summary_bit;
          st_nxt.cnt = 5'h00;
        end
      end
      DDSP_SHIFT: begin
        if (sclk_rise) begin
          st_nxt.samp = st_r.mosi_s[1];
        end
        if (sclk_fall) begin
          // Out bit leaves the top while the sampled in bit enters the bottom
          st_nxt.dout = st_r.shreg[FRAME_BITS-1];
          st_nxt.shreg = {st_r.shreg[FRAME_BITS-2:0], st_r.samp};
          if (!frame_ok) begin
            st_nxt.cnt = st_r.cnt + 5'h01;
          end
        end
        if (csn_rise) begin
          st_nxt.state = DDSP_IDLE;
          if (frame_ok) begin
            // The word named last frame has just gone out, so a pending clear runs now
            if (st_r.clr_pend) begin
              st_nxt.stat[st_r.sel] = '0;
              st_nxt.thermal_shutdown_flag = 1'b0;
            end
            st_nxt.ctrl[st_r.shreg[ADDR_MSB:ADDR_LSB]] =
              st_r.shreg[FRAME_BITS-1:CTRL_LSB];
            st_nxt.sel = st_r.shreg[ADDR_MSB:ADDR_LSB];
            st_nxt.clr_pend = st_r.shreg[CLR_POS];
          end
        end
      end
    endcase
    // Hardware events win over a clear in the same cycle
    st_nxt.stat = st_nxt.stat | set_masked;
    st_nxt.thermal_shutdown_flag = st_nxt.thermal_shutdown_flag | thermal_shutdown_evt_in;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st_r <= '0;
      st_r.state <= DDSP_IDLE;
      st_r.csn_s <= 3'h7;
      st_r.sel <= ADDR_RESET;
      st_r.ctrl <= {NUM_WORDS{CTRL_RESET}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign miso_out = st_r.dout;
  assign miso_oe_out = (st_r.state == DDSP_SHIFT);

  ddsp_gate_if gate_bus ();

  assign gate_bus.stage_on = st_r.ctrl[CTRL_ON_WORD][NUM_STAGES-1:0];
  assign gate_bus.gate_a_select = st_r.ctrl[CTRL_SEL_A_WORD][NUM_STAGES-1:0];
  assign gate_bus.gate_b_select = st_r.ctrl[CTRL_SEL_B_WORD][NUM_STAGES-1:0];

  ddsp_pwm_gate u_gate (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .direct_gate_input_a_in(direct_gate_input_a_in),
    .direct_gate_input_b_in(direct_gate_input_b_in),
    .cfg(gate_bus.gate),
    .stage_drive_out(stage_drive_out)
  );

  default clocking diag_cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  AST_NC_LOW: assert property (
    (st_r.stat & ~FLAG_MASK) == '0)
    else $error("unconnected status position reads high");

  AST_FLAG_SET: assert property (
    (set_masked != '0) |=> ((st_r.stat & $past(set_masked)) == $past(set_masked)))
    else $error("overload or open-load event not latched");

  AST_FLAG_HOLD: assert property (
    (!csn_rise && set_masked == '0) |=> $stable(st_r.stat))
    else $error("status flags changed without event or frame end");

  AST_EF_FIRST: assert property (
    (st_r.state == DDSP_IDLE && csn_fall) |=> (miso_out == $past(error_summary_bit)) && miso_oe_out)
    else $error("summary bit not on serial output after select fall");

  AST_WORD_LOAD: assert property (
    (st_r.state == DDSP_IDLE && csn_fall) |=>
      (st_r.shreg[FRAME_BITS-1:FLAG_LSB] == $past(st_r.stat[st_r.sel])))
    else $error("loaded word does not match selected status word");

  AST_FIXED_BITS: assert property (
    (st_r.state == DDSP_IDLE && csn_fall) |=>
      (st_r.shreg[SUPPLY_POS:TW_POS] == {$past(supply_fault_flag_in),
       $past(st_r.thermal_shutdown_flag), $past(temperature_warning_flag_in)}))
    else $error("supply, shutdown or warning bits misplaced");

  AST_SUMMARY: assert property (
    (st_r.state == DDSP_IDLE && csn_fall) |=>
      (miso_out == ($past(st_r.stat) != '0)))
    else $error("summary bit disagrees with status words");

  AST_SHIFT_OUT: assert property (
    (st_r.state == DDSP_SHIFT && sclk_fall && !csn_rise) |=>
      (miso_out == $past(st_r.shreg[FRAME_BITS-1])) &&
      (st_r.shreg[0] == $past(st_r.samp)))
    else $error("serial shift order broken");

  AST_SHIFT_COUNT: assert property (
    (st_r.state == DDSP_SHIFT) |-> (st_r.cnt <= FRAME_LEN))
    else $error("bit count passed frame length");

  AST_COMMIT_ONLY: assert property (
    !csn_rise |=> $stable(st_r.sel) && $stable(st_r.ctrl) && $stable(st_r.clr_pend))
    else $error("frame contents applied before select rise");

  AST_NEXT_ADDR: assert property (
    (st_r.state == DDSP_SHIFT && csn_rise && frame_ok) |=>
      (st_r.sel == $past(st_r.shreg[ADDR_MSB:ADDR_LSB])) &&
      (st_r.clr_pend == $past(st_r.shreg[CLR_POS])))
    else $error("address or clear bit not taken at frame end");

  AST_RESET_ADDR: assert property (
    $rose(rstn_in) |-> (st_r.sel == ADDR_RESET) && !st_r.clr_pend)
    else $error("status address not zero after reset");

  AST_CLEAR_LATE: assert property (
    (st_r.state == DDSP_SHIFT && csn_rise && frame_ok && st_r.clr_pend && set_masked == '0) |=>
      (st_r.stat[$past(st_r.sel)] == '0))
    else $error("requested status clear not executed");

  AST_TSD_CLEAR: assert property (
    (st_r.state == DDSP_SHIFT && csn_rise && frame_ok && st_r.clr_pend
     && !thermal_shutdown_evt_in) |=> !st_r.thermal_shutdown_flag)
    else $error("thermal shutdown flag kept after word clear");

  AST_SHORT_FRAME: assert property (
    (st_r.state == DDSP_SHIFT && csn_rise && !frame_ok) |=>
      $stable(st_r.sel) && (st_r.state == DDSP_IDLE))
    else $error("short frame was applied");

endmodule // ddsp_spi_diag

// File: verification/ddsp_spi_diag_bench.sv
// Purpose: Self-checking bench of the serial diagnosis and stage gating block
// Assumes: Status events are raised all at once so unconnected positions are exercised
// Notes: Each frame returns the word chosen by the frame before it
module ddsp_spi_diag_bench;
  import ddsp_pkg::*;
  timeunit 1ns;
  timeprecision 10ps;

  logic sys_clk, rstn, sclk, chip_select_low, mosi, miso, miso_oe, pin_a, pin_b;
  logic supply, tsd_evt, warn;
  logic [NUM_WORDS*WORD_FLAGS-1:0] status_set;
  logic [NUM_STAGES-1:0] drive, exp_drive;
  logic [15:0] words [4] = '{16'hFE3F, 16'hAA3F, 16'hFFFF, 16'hAFFF};
  logic [7:0] on_bits = 8'hFE, sel_a = 8'h0D, sel_b = 8'h0A;
  int fail_count, checks_done;

  ddsp_spi_diag u_ddsp_spi_diag (
    .sys_clk_in(sys_clk), .rstn_in(rstn), .sclk_in(sclk), .chip_select_low_in(chip_select_low),
    .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe),
    .direct_gate_input_a_in(pin_a), .direct_gate_input_b_in(pin_b),
    .status_set_in(status_set), .supply_fault_flag_in(supply),
    .thermal_shutdown_evt_in(tsd_evt), .temperature_warning_flag_in(warn),
    .stage_drive_out(drive)
  );

  ddsp_spi_master u_ddsp_spi_master (
    .miso_in(miso), .sclk_out(sclk), .chip_select_low_out(chip_select_low), .mosi_out(mosi)
  );

  always #4 sys_clk = ~sys_clk;

  task automatic check(input logic [16:0] seen, input logic [16:0] expv);
    checks_done++;
    if (seen !== expv) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Start off the clock edges so link edges never meet a sampling edge
  task automatic xfer(input logic [15:0] tx, input int falls, input logic [16:0] expv);
    logic [16:0] rx;
    @(negedge sys_clk);
    #0.25;
    u_ddsp_spi_master.frame(tx, falls, rx);
    if (falls == 16) begin
      check(rx, expv);
    end
    check({16'h0000, miso_oe}, 17'h00000);
  endtask

  initial begin
    #700us;
    fail_count++;
    results();
  end

  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    pin_a = 1'b0;
    pin_b = 1'b0;
    supply = 1'b0;
    tsd_evt = 1'b0;
    warn = 1'b0;
    status_set = '0;
    fail_count = 0;
    checks_done = 0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rstn = 1'b1;
    repeat (10) @(negedge sys_clk);
    xfer(16'h0000, 16, 17'h00000);
    // Every event line high, unconnected ones included
    @(negedge sys_clk);
    status_set = '1;
    supply = 1'b1;
    tsd_evt = 1'b1;
    warn = 1'b1;
    @(negedge sys_clk);
    status_set = '0;
    tsd_evt = 1'b0;
    for (int a = 0; a < 4; a++) begin
      xfer(16'((a + 1) % 4), 16, {1'b1, words[a]});
    end
    xfer(16'h0005, 16, {1'b1, words[0]});
    xfer(16'h0000, 16, {1'b1, words[1]});
    xfer(16'h0001, 16, {1'b1, 16'hFE2E});
    xfer(16'h0002, 16, {1'b1, 16'h002F});
    // Short frame must leave the selection alone
    xfer(16'h0003, 15, 17'h00000);
    xfer(16'h0000, 16, {1'b1, 16'hFFED});
    xfer({5'h00, on_bits, 3'h0}, 16, {1'b1, 16'hFE2E});
    xfer({5'h00, sel_a, 3'h1}, 16, {1'b1, 16'hFE2E});
    xfer({5'h00, sel_b, 3'h3}, 16, {1'b1, 16'h002F});
    // Gate rate is only a recommendation; pins toggle fast here to keep the run short
    for (int ab = 0; ab < 4; ab++) begin
      @(negedge sys_clk);
      pin_a = ab[0];
      pin_b = ab[1];
      exp_drive = on_bits & ((~sel_a & ~sel_b) | (sel_a & {8{pin_a}}) | (sel_b & {8{pin_b}}));
      repeat (5) @(negedge sys_clk);
      check({9'h000, drive}, {9'h000, exp_drive});
    end
    results();
  end
endmodule // ddsp_spi_diag_bench

// File: verification/ddsp_spi_master.sv
// Purpose: Behavioural serial master that sits in front of the diagnosis port
// Assumes: Serial clock idles low, data sampled by the device on rising edges
// Notes: Caller aligns the start off the system clock edges
module ddsp_spi_master (
  input wire logic miso_in,
  output logic sclk_out,
  output logic chip_select_low_out,
  output logic mosi_out
);
  timeunit 1ns;
  timeprecision 10ps;
  localparam realtime HALF = 62.5;

  initial begin
    sclk_out = 1'b0;
    chip_select_low_out = 1'b1;
    mosi_out = 1'b0;
  end

  // Address goes out in one frame, the word comes back in the next
  task automatic frame(input logic [15:0] tx, input int falls, output logic [16:0] rx);
    rx = 17'h00000;
    chip_select_low_out = 1'b0;
    #HALF;
    for (int i = 0; i < falls; i++) begin
      mosi_out = tx[15-i];
      #HALF;
      sclk_out = 1'b1;
      rx[16-i] = miso_in;
      #HALF;
      sclk_out = 1'b0;
    end
    #HALF;
    rx[0] = miso_in;
    chip_select_low_out = 1'b1;
    // Released data line must not keep its last level
    mosi_out = ~mosi_out;
    #5000;
  endtask
endmodule // ddsp_spi_master
